/* File: hw/cdfs_pkg.sv */
package cdfs_pkg;

  // bus geometry
  localparam int ADDR_W = 14;
  localparam int DATA_W = 32;
  localparam int IDX_W = 12;

  // register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_AUX_CMP = 12'h543;
  localparam logic [IDX_W-1:0] IDX_CELL_CMP_HI = 12'h545;
  localparam logic [IDX_W-1:0] IDX_CELL_CMP_LO = 12'h546;
  localparam logic [IDX_W-1:0] IDX_CELL_OW_HI = 12'h548;
  localparam logic [IDX_W-1:0] IDX_CELL_OW_LO = 12'h549;
  localparam logic [IDX_W-1:0] IDX_BAL_OW_HI = 12'h54b;
  localparam logic [IDX_W-1:0] IDX_BAL_OW_LO = 12'h54c;
  localparam logic [IDX_W-1:0] IDX_BAL_SW_HI = 12'h54e;
  localparam logic [IDX_W-1:0] IDX_BAL_SW_LO = 12'h54f;
  localparam logic [IDX_W-1:0] IDX_THR_CFG = 12'h560;
  localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 12'h561;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 12'h562;
  localparam logic [IDX_W-1:0] IDX_SUMMARY = 12'h563;

  // result slots
  localparam int NUM_SLOTS = 9;
  localparam logic [3:0] SLOT_AUX = 4'h0;
  localparam logic [3:0] SLOT_CELL_CMP_HI = 4'h1;
  localparam logic [3:0] SLOT_CELL_CMP_LO = 4'h2;
  localparam logic [3:0] SLOT_CELL_OW_HI = 4'h3;
  localparam logic [3:0] SLOT_CELL_OW_LO = 4'h4;
  localparam logic [3:0] SLOT_BAL_OW_HI = 4'h5;
  localparam logic [3:0] SLOT_BAL_OW_LO = 4'h6;
  localparam logic [3:0] SLOT_BAL_SW_HI = 4'h7;
  localparam logic [3:0] SLOT_BAL_SW_LO = 4'h8;
  localparam logic [3:0] SLOT_NONE = 4'hf;

  // threshold configuration fields
  localparam int AUX_THR_LSB = 0;
  localparam int AUX_THR_W = 3;
  localparam int CELL_THR_LSB = 8;
  localparam int CELL_THR_W = 5;
  localparam int OPEN_WIRE_THRESHOLD_LSB = 16;
  localparam int OPEN_WIRE_THRESHOLD_W = 4;
  localparam logic [DATA_W-1:0] THR_CFG_RESET = 32'h0000_0000;

  // reading code per threshold step
  localparam int RD_W = 16;
  localparam int AUX_THR_SHIFT = 4;
  localparam int CELL_THR_SHIFT = 4;
  localparam int OPEN_WIRE_THRESHOLD_SHIFT = 8;

  // interrupt layout: one bit per diagnostic kind
  localparam int NUM_KINDS = 5;
  localparam logic [7:0] RESULT_RESET = 8'h00;
  localparam logic [NUM_KINDS-1:0] IRQ_RESET = 5'h00;

  typedef enum logic [2:0] {
    KIND_AUX_CMP,
    KIND_CELL_CMP,
    KIND_CELL_OW,
    KIND_BAL_OW,
    KIND_BAL_SW
  } cdfs_kind_e;

endpackage

/* File: hw/cdfs_judge.sv */
`timescale 1ns/10ps
module cdfs_judge (
  // diagnostic sample
  input wire logic [2:0] kind,
  input wire logic [cdfs_pkg::RD_W-1:0] reading_a,
  input wire logic [cdfs_pkg::RD_W-1:0] reading_b,
  input wire logic ext_fail,
  // thresholds
  input wire logic [cdfs_pkg::AUX_THR_W-1:0] aux_input_compare_threshold,
  input wire logic [cdfs_pkg::CELL_THR_W-1:0] cell_compare_threshold,
  input wire logic [cdfs_pkg::OPEN_WIRE_THRESHOLD_W-1:0] open_wire_threshold,
  // verdict
  output logic fail
);
  logic [cdfs_pkg::RD_W-1:0] diff;
  logic [cdfs_pkg::RD_W-1:0] aux_lim;
  logic [cdfs_pkg::RD_W-1:0] cell_lim;
  logic [cdfs_pkg::RD_W-1:0] ow_lim;

  always_comb begin
    diff = (reading_a >= reading_b) ? (reading_a - reading_b) : (reading_b - reading_a);
    aux_lim = cdfs_pkg::RD_W'({13'h0000, aux_input_compare_threshold}) << cdfs_pkg::AUX_THR_SHIFT;
    cell_lim = cdfs_pkg::RD_W'({11'h000, cell_compare_threshold}) << cdfs_pkg::CELL_THR_SHIFT;
    ow_lim = cdfs_pkg::RD_W'({12'h000, open_wire_threshold}) << cdfs_pkg::OPEN_WIRE_THRESHOLD_SHIFT;
    case (kind)
      cdfs_pkg::KIND_AUX_CMP: fail = diff > aux_lim;
      cdfs_pkg::KIND_CELL_CMP: fail = diff > cell_lim;
      cdfs_pkg::KIND_CELL_OW: fail = reading_a < ow_lim;
      // switch checks are judged by the analog side; only the verdict arrives
      cdfs_pkg::KIND_BAL_OW: fail = ext_fail;
      cdfs_pkg::KIND_BAL_SW: fail = ext_fail;
      default: fail = 1'b0;
    endcase
  end
endmodule // cdfs_judge

/* File: hw/cdfs_bank.sv */
// What this block does
// - aux input fails when main and auxiliary readings differ beyond aux threshold
// - aux inputs 1..8 results at 0x0543, input 1 in bit 0
// - cell compare fails when primary and auxiliary readings differ beyond cell threshold
// - cells 9..16 compare results at 0x0545, cell 9 in bit 0
// - cells 1..8 compare results at 0x0546, cell 1 in bit 0
// - cell open-wire fails when reading is below open-wire threshold
// - cell open-wire results: cells 9..16 at 0x0548, cells 1..8 at 0x0549
// - balancing open-wire results: switches 9..16 at 0x054B, 1..8 at 0x054C
// - balancing switch check results for switches 9..16 at 0x054E
// - balancing switch check results for switches 1..8 at 0x054F
//
// The Avalon-MM interface to the registers was decided locally.
`timescale 1ns/10ps
module cdfs_bank (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // avalon-mm slave
  input wire logic [cdfs_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [cdfs_pkg::DATA_W-1:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [cdfs_pkg::DATA_W-1:0] readdata,
  output logic waitrequest,
  // diagnostic completion from the sequencer
  input wire logic diag_done,
  input wire logic [2:0] diag_kind,
  input wire logic [3:0] diag_chan,
  input wire logic [cdfs_pkg::RD_W-1:0] primary_cell_reading,
  input wire logic [cdfs_pkg::RD_W-1:0] auxiliary_cell_reading,
  input wire logic diag_ext_fail,
  // summary and interrupt
  output logic any_fail,
  output logic irq
);

  logic [7:0] res_r [cdfs_pkg::NUM_SLOTS];
  logic [7:0] res_nxt [cdfs_pkg::NUM_SLOTS];
  logic [cdfs_pkg::DATA_W-1:0] thr_r;
  logic [cdfs_pkg::DATA_W-1:0] thr_nxt;
  logic [cdfs_pkg::NUM_KINDS-1:0] ists_r;
  logic [cdfs_pkg::NUM_KINDS-1:0] ists_nxt;
  logic [cdfs_pkg::NUM_KINDS-1:0] imask_r;
  logic [cdfs_pkg::NUM_KINDS-1:0] imask_nxt;
  logic [cdfs_pkg::NUM_KINDS-1:0] ev;
  logic ack_r;
  logic ack_nxt;
  logic [cdfs_pkg::DATA_W-1:0] rdata_r;
  logic [cdfs_pkg::DATA_W-1:0] rdata_nxt;
  logic any_fail_r;
  logic any_fail_nxt;
  logic irq_r;
  logic irq_nxt;
  logic judge_fail;
  logic [3:0] upd_slot;
  logic [cdfs_pkg::IDX_W-1:0] idx;
  logic wr_take;
  logic [7:0] or_vec;

  // map a register index to its result slot
  function automatic logic [3:0] slot_of_idx(input logic [cdfs_pkg::IDX_W-1:0] i);
    case (i)
      cdfs_pkg::IDX_AUX_CMP: slot_of_idx = cdfs_pkg::SLOT_AUX;
      cdfs_pkg::IDX_CELL_CMP_HI: slot_of_idx = cdfs_pkg::SLOT_CELL_CMP_HI;
      cdfs_pkg::IDX_CELL_CMP_LO: slot_of_idx = cdfs_pkg::SLOT_CELL_CMP_LO;
      cdfs_pkg::IDX_CELL_OW_HI: slot_of_idx = cdfs_pkg::SLOT_CELL_OW_HI;
      cdfs_pkg::IDX_CELL_OW_LO: slot_of_idx = cdfs_pkg::SLOT_CELL_OW_LO;
      cdfs_pkg::IDX_BAL_OW_HI: slot_of_idx = cdfs_pkg::SLOT_BAL_OW_HI;
      cdfs_pkg::IDX_BAL_OW_LO: slot_of_idx = cdfs_pkg::SLOT_BAL_OW_LO;
      cdfs_pkg::IDX_BAL_SW_HI: slot_of_idx = cdfs_pkg::SLOT_BAL_SW_HI;
      cdfs_pkg::IDX_BAL_SW_LO: slot_of_idx = cdfs_pkg::SLOT_BAL_SW_LO;
      default: slot_of_idx = cdfs_pkg::SLOT_NONE;
    endcase
  endfunction

  // map a finished check to its result slot; channel 0..15 is cell or switch 1..16
  function automatic logic [3:0] slot_of_diag(input logic [2:0] k, input logic hi);
    case (k)
      cdfs_pkg::KIND_AUX_CMP: slot_of_diag = hi ? cdfs_pkg::SLOT_NONE : cdfs_pkg::SLOT_AUX;
      cdfs_pkg::KIND_CELL_CMP: slot_of_diag = hi ? cdfs_pkg::SLOT_CELL_CMP_HI : cdfs_pkg::SLOT_CELL_CMP_LO;
      cdfs_pkg::KIND_CELL_OW: slot_of_diag = hi ? cdfs_pkg::SLOT_CELL_OW_HI : cdfs_pkg::SLOT_CELL_OW_LO;
      cdfs_pkg::KIND_BAL_OW: slot_of_diag = hi ? cdfs_pkg::SLOT_BAL_OW_HI : cdfs_pkg::SLOT_BAL_OW_LO;
      cdfs_pkg::KIND_BAL_SW: slot_of_diag = hi ? cdfs_pkg::SLOT_BAL_SW_HI : cdfs_pkg::SLOT_BAL_SW_LO;
      default: slot_of_diag = cdfs_pkg::SLOT_NONE;
    endcase
  endfunction

  cdfs_judge u_judge (
    .kind(diag_kind),
    .reading_a(primary_cell_reading),
    .reading_b(auxiliary_cell_reading),
    .ext_fail(diag_ext_fail),
    .aux_input_compare_threshold(thr_r[cdfs_pkg::AUX_THR_LSB +: cdfs_pkg::AUX_THR_W]),
    .cell_compare_threshold(thr_r[cdfs_pkg::CELL_THR_LSB +: cdfs_pkg::CELL_THR_W]),
    .open_wire_threshold(thr_r[cdfs_pkg::OPEN_WIRE_THRESHOLD_LSB +: cdfs_pkg::OPEN_WIRE_THRESHOLD_W]),
    .fail(judge_fail)
  );

  assign idx = address[cdfs_pkg::ADDR_W-1:2];
  assign upd_slot = slot_of_diag(diag_kind, diag_chan[3]);

  // one wait cycle per access; the second cycle carries the answer
  assign waitrequest = (read | write) & ~ack_r;
  assign wr_take = write & ack_r;
  assign readdata = rdata_r;
  assign any_fail = any_fail_r;
  assign irq = irq_r;

  // result slots: only a finished check writes a bit, bus writes never reach here
  always_comb begin
    res_nxt = res_r;
    ev = '0;
    if (diag_done && upd_slot != cdfs_pkg::SLOT_NONE) begin
      res_nxt[upd_slot][diag_chan[2:0]] = judge_fail;
      ev[diag_kind] = judge_fail;
    end
  end

  // summary of every failure bit
  always_comb begin
    or_vec = '0;
    for (int s = 0; s < cdfs_pkg::NUM_SLOTS; s++) begin
      or_vec = or_vec | res_nxt[s];
    end
    any_fail_nxt = |or_vec;
  end

  // bus side: thresholds, mask, sticky status with set over clear
  always_comb begin
    thr_nxt = thr_r;
    imask_nxt = imask_r;
    ack_nxt = (read | write) & ~ack_r;
    if (wr_take && idx == cdfs_pkg::IDX_THR_CFG) begin
      for (int b = 0; b < 4; b++) begin
        if (byteenable[b]) begin
          thr_nxt[b*8 +: 8] = writedata[b*8 +: 8];
        end
      end
    end
    if (wr_take && idx == cdfs_pkg::IDX_IRQ_MASK && byteenable[0]) begin
      imask_nxt = writedata[cdfs_pkg::NUM_KINDS-1:0];
    end
    ists_nxt = ists_r;
    if (wr_take && idx == cdfs_pkg::IDX_IRQ_STATUS && byteenable[0]) begin
      ists_nxt = ists_r & ~writedata[cdfs_pkg::NUM_KINDS-1:0];
    end
    ists_nxt = ists_nxt | ev;
    irq_nxt = |(ists_nxt & imask_nxt);
  end

  // read mux, latched in the wait cycle so data stands with waitrequest low
  always_comb begin
    logic [3:0] rs;
    rs = slot_of_idx(idx);
    rdata_nxt = rdata_r;
    if (read && !ack_r) begin
      if (rs != cdfs_pkg::SLOT_NONE) begin
        rdata_nxt = {24'h000000, res_r[rs]};
      end else begin
        case (idx)
          cdfs_pkg::IDX_THR_CFG: rdata_nxt = thr_r;
          cdfs_pkg::IDX_IRQ_STATUS: rdata_nxt = {27'h0000000, ists_r};
          cdfs_pkg::IDX_IRQ_MASK: rdata_nxt = {27'h0000000, imask_r};
          cdfs_pkg::IDX_SUMMARY: rdata_nxt = {31'h00000000, any_fail_r};
          default: rdata_nxt = 32'h0000_0000;
        endcase
      end
    end
  end

  // result registers, one per slot
  genvar g;
  generate
    for (g = 0; g < cdfs_pkg::NUM_SLOTS; g++) begin : g_res
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          res_r[g] <= cdfs_pkg::RESULT_RESET;
        end else begin
          res_r[g] <= res_nxt[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      thr_r <= cdfs_pkg::THR_CFG_RESET;
      imask_r <= cdfs_pkg::IRQ_RESET;
      ists_r <= cdfs_pkg::IRQ_RESET;
      ack_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      any_fail_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      thr_r <= thr_nxt;
      imask_r <= imask_nxt;
      ists_r <= ists_nxt;
      ack_r <= ack_nxt;
      rdata_r <= rdata_nxt;
      any_fail_r <= any_fail_nxt;
      irq_r <= irq_nxt;
    end
  end

endmodule // cdfs_bank

/* File: dv/cdfs_bank_chk.sv */
`timescale 1ns/10ps
module cdfs_bank_chk (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // bus
  input wire logic read,
  input wire logic write,
  input wire logic waitrequest,
  input wire logic [cdfs_pkg::DATA_W-1:0] readdata,
  // diagnostics and summary
  input wire logic diag_done,
  input wire logic [2:0] diag_kind,
  input wire logic diag_ext_fail,
  input wire logic any_fail,
  input wire logic irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_req; $rose(read || write); endsequence
  sequence s_ans; waitrequest ##1 !waitrequest; endsequence
  property p_ans; s_req |-> s_ans; endproperty
  a_ans: assert property (p_ans) else $error("bus answer not after one wait cycle");
  property p_one; (read || write) && !waitrequest |=> !(read || write) || waitrequest; endproperty
  a_one: assert property (p_one) else $error("bus answered twice for one request");
  property p_idle; !(read || write) |-> !waitrequest; endproperty
  a_idle: assert property (p_idle) else $error("waitrequest high while idle");
  property p_ext; diag_done && diag_ext_fail && diag_kind inside {3'h3, 3'h4} |=> any_fail; endproperty
  a_ext: assert property (p_ext) else $error("switch failure not summarised");
  // results only move when a check completes, so the summary must follow the same
  property p_any; $changed(any_fail) |-> $past(diag_done); endproperty
  a_any: assert property (p_any) else $error("summary changed without a check");
  property p_irq_rise; $rose(irq) |-> $past(diag_done || write); endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("irq rose without cause");
  property p_irq_fall; $fell(irq) |-> $past(write); endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell without a write");
  property p_rdata; $changed(readdata) |-> $past(read); endproperty
  a_rdata: assert property (p_rdata) else $error("readdata changed outside a read");
endmodule // cdfs_bank_chk
bind cdfs_bank cdfs_bank_chk u_chk (.clk(clk), .nrst(nrst), .read(read), .write(write), .waitrequest(waitrequest),
  .readdata(readdata), .diag_done(diag_done), .diag_kind(diag_kind), .diag_ext_fail(diag_ext_fail),
  .any_fail(any_fail), .irq(irq));

/* File: dv/cdfs_bank_tb.sv */
`timescale 1ns/10ps
module cdfs_bank_tb;
  logic clk, nrst, read, write, diag_done, diag_ext_fail, any_fail, irq, waitrequest;
  logic [13:0] address;
  logic [31:0] writedata, readdata, rd;
  logic [3:0] diag_chan;
  logic [2:0] diag_kind;
  logic [15:0] pa, pb;
  int failures, check_count, cyc;
  logic [11:0] idx_t [9] = '{cdfs_pkg::IDX_AUX_CMP, cdfs_pkg::IDX_CELL_CMP_HI, cdfs_pkg::IDX_CELL_CMP_LO,
    cdfs_pkg::IDX_CELL_OW_HI, cdfs_pkg::IDX_CELL_OW_LO, cdfs_pkg::IDX_BAL_OW_HI, cdfs_pkg::IDX_BAL_OW_LO,
    cdfs_pkg::IDX_BAL_SW_HI, cdfs_pkg::IDX_BAL_SW_LO};
  logic [2:0] kd [9] = '{3'h0, 3'h1, 3'h1, 3'h2, 3'h2, 3'h3, 3'h3, 3'h4, 3'h4};
  logic [3:0] ch [9] = '{4'h3, 4'h9, 4'h0, 4'hc, 4'h1, 4'hf, 4'h0, 4'h8, 4'h7};
  logic [15:0] fa [9] = '{16'h100, 16'h200, 16'h231, 16'h3ff, 16'h3ff, 16'h0, 16'h0, 16'h0, 16'h0};
  logic [15:0] fb [9] = '{16'h121, 16'h231, 16'h200, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0};
  logic [7:0] ex [9] = '{8'h08, 8'h02, 8'h01, 8'h10, 8'h02, 8'h80, 8'h01, 8'h01, 8'h80};

  cdfs_bank u_dut (.clk(clk), .nrst(nrst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(4'hf), .readdata(readdata), .waitrequest(waitrequest),
    .diag_done(diag_done), .diag_kind(diag_kind), .diag_chan(diag_chan), .primary_cell_reading(pa),
    .auxiliary_cell_reading(pb), .diag_ext_fail(diag_ext_fail), .any_fail(any_fail), .irq(irq));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task end_of_test();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      end_of_test();
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // waitrequest and read data are taken at the rising edge, as the master sees them there
  task bus(input logic wr, input logic [11:0] idx, input logic [31:0] wd);
    @(posedge clk);
    address <= {idx, 2'b00};
    read <= !wr;
    write <= wr;
    writedata <= wd;
    do @(posedge clk); while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task rdchk(input logic [11:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 32'h0);
    chk(rd, exp);
  endtask

  task diag(input logic [2:0] k, input logic [3:0] c, input logic [15:0] a, input logic [15:0] b, input logic e);
    @(posedge clk);
    diag_done <= 1'b1;
    diag_kind <= k;
    diag_chan <= c;
    pa <= a;
    pb <= b;
    diag_ext_fail <= e;
    @(posedge clk);
    diag_done <= 1'b0;
  endtask

  initial begin
    nrst = 1'b0; read = 1'b0; write = 1'b0; address = 14'h0; writedata = 32'h0;
    diag_done = 1'b0; diag_kind = 3'h0; diag_chan = 4'h0; pa = 16'h0; pb = 16'h0; diag_ext_fail = 1'b0;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      rdchk(idx_t[i], 32'h0);
      bus(1'b1, idx_t[i], 32'hff);
      rdchk(idx_t[i], 32'h0);
    end
    $display("reset and read-only test done");
    bus(1'b1, cdfs_pkg::IDX_THR_CFG, 32'h0004_0302);
    bus(1'b1, cdfs_pkg::IDX_IRQ_MASK, 32'h1f);
    for (int i = 0; i < 9; i++) diag(kd[i], ch[i], fa[i], fb[i], 1'b1);
    // threshold edges pass and an out-of-range aux channel is dropped
    diag(3'h0, 4'h5, 16'h100, 16'h0e0, 1'b0);
    diag(3'h1, 4'h7, 16'h200, 16'h230, 1'b0);
    diag(3'h2, 4'h2, 16'h400, 16'h0, 1'b0);
    diag(3'h0, 4'h9, 16'h0, 16'hfff, 1'b0);
    for (int i = 0; i < 9; i++) rdchk(idx_t[i], {24'h0, ex[i]});
    @(negedge clk);
    chk(any_fail, 1'b1);
    chk(irq, 1'b1);
    rdchk(cdfs_pkg::IDX_IRQ_STATUS, 32'h1f);
    rdchk(cdfs_pkg::IDX_SUMMARY, 32'h1);
    rdchk(12'h700, 32'h0);
    $display("fail mapping test done");
    bus(1'b1, cdfs_pkg::IDX_IRQ_STATUS, 32'h1f);
    rdchk(cdfs_pkg::IDX_IRQ_STATUS, 32'h0);
    @(negedge clk);
    chk(irq, 1'b0);
    bus(1'b1, cdfs_pkg::IDX_IRQ_MASK, 32'h0);
    diag(3'h3, 4'hf, 16'h0, 16'h0, 1'b1);
    @(negedge clk);
    chk(irq, 1'b0);
    rdchk(cdfs_pkg::IDX_IRQ_STATUS, 32'h08);
    bus(1'b1, cdfs_pkg::IDX_IRQ_MASK, 32'h08);
    rdchk(cdfs_pkg::IDX_BAL_OW_HI, 32'h80);
    @(negedge clk);
    chk(irq, 1'b1);
    $display("interrupt test done");
    for (int i = 0; i < 9; i++) diag(kd[i], ch[i], 16'hffff, 16'hffff, 1'b0);
    for (int i = 0; i < 9; i++) rdchk(idx_t[i], 32'h0);
    @(negedge clk);
    chk(any_fail, 1'b0);
    rdchk(cdfs_pkg::IDX_SUMMARY, 32'h0);
    $display("pass update test done");
    end_of_test();
  end
endmodule // cdfs_bank_tb
